//--- core/byte_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rd_r];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= bump(wr_r);
      end
      if (pop) begin
        rd_r <= bump(rd_r);
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

//--- core/lcd_ctl_cfg.svh
// Constants for the character display write controller
`ifndef LCD_CTL_CFG_SVH
`define LCD_CTL_CFG_SVH
`define CLK_PERIOD_NS 10
`define STEP_WAIT_MS 16
`define STEP_WAIT_CYCLES ((`STEP_WAIT_MS * 1000000) / `CLK_PERIOD_NS)
`define E_PULSE_NS 500
`define E_PULSE_CYCLES (((`E_PULSE_NS) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_CODE_COUNT 4
`define CMD_FUNCTION_SET 8'h38
`define CMD_ENTRY_MODE 8'h06
`define CMD_DISPLAY_ON 8'h0e
`define CMD_CLEAR 8'h01
`define CMD_HOME_ADDR 8'h80
`define RS_COMMAND 1'b0
`define RS_DATA 1'b1
`define RW_WRITE 1'b0
`define FIFO_DEPTH 16
`define BYTE_WIDTH 8
`endif

//--- core/lcd_ctl_pkg.sv
// Types for the character display write controller
package lcd_ctl_pkg;
  typedef enum logic [2:0] {
    PU_WAIT, PU_SEND, PU_HOLD, PU_DONE
  } pu_state_type;
  typedef enum logic [2:0] {
    MN_IDLE, MN_SETUP, MN_STROBE, MN_HOLD, MN_GAP
  } main_state_type;
endpackage

//--- core/lcd_write_ctl.sv
// Character display write controller: power-up sequencer and writer
// Operation
// [R1] Display latches byte on enable falling edge
// [R2] Read/write line held at write always
// [R3] Wait, then send 0x38, 0x06, 0x0e, 0x01
// [R4] Initialization restarts after every reset
// [R5] Each init step held 16 ms
// [R6] Sequencer signals done to main machine
// [R7] Ready high once initialization completes
// [R8] Strobe falling edge captures byte, drops ready
// [R9] Strobes ignored while ready is low
// [R10] Host writes only while ready high
// [R11] Ends with cursor on, cleared, auto-increment
// [R12] Sequence framed by 0x00 and 0x80
// [R13] Active-high reset restarts power-up sequence
// [R14] Active-high host strobe delivers 8-bit byte
// [R15] Timing counts derived from clock rate
// [R16] Commands use command select, characters data
// [R17] Capture uses strobe falling edge only
`timescale 1ns/10ps
`include "lcd_ctl_cfg.svh"
module lcd_write_ctl
  import lcd_ctl_pkg::*;
#(
  parameter int STEP_WAIT = `STEP_WAIT_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Host side
  input wire logic [7:0] host_byte_in,
  input wire logic host_write,
  output logic ready,
  // Display module side
  output logic display_register_select_out,
  output logic display_rw_out,
  output logic display_enable_out,
  output logic [7:0] display_byte_out
);
  localparam int CW = $clog2(STEP_WAIT + 1);
  localparam int EW = $clog2(`E_PULSE_CYCLES + 1);

  pu_state_type pu_r;
  main_state_type mn_r;
  logic [CW-1:0] wait_r;
  logic [2:0] code_idx_r;
  logic init_done_r;
  logic strobe_d_r;
  logic [7:0] latch_r;
  logic ready_r;
  logic [EW-1:0] e_cnt_r;
  logic rs_r;
  logic e_r;
  logic [7:0] db_r;
  logic strobe_fall;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic pu_e;
  logic [7:0] pu_byte;
  logic wait_end;

  // Init codes, framed by a null lead-in and a home-address trailer
  function automatic logic [7:0] init_code(input logic [2:0] i);
    case (i)
      3'h0: init_code = 8'h00; // see [R12]
      3'h1: init_code = `CMD_FUNCTION_SET; // see [R3]
      3'h2: init_code = `CMD_ENTRY_MODE; // see [R11]
      3'h3: init_code = `CMD_DISPLAY_ON;
      3'h4: init_code = `CMD_CLEAR;
      default: init_code = `CMD_HOME_ADDR; // see [R12]
    endcase
  endfunction

  assign wait_end = (wait_r == CW'(STEP_WAIT - 1)); // see [R5] see [R15]
  assign pu_byte = init_code(code_idx_r);

  // Power-up sequencer: wait, then strobe each code with a full step hold
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin // see [R4] see [R13]
      pu_r <= PU_WAIT;
      wait_r <= '0;
      code_idx_r <= '0;
      init_done_r <= 1'b0;
    end else begin
      case (pu_r)
        PU_WAIT: begin
          wait_r <= wait_end ? '0 : wait_r + 1'b1;
          if (wait_end) begin
            pu_r <= PU_SEND;
          end
        end
        PU_SEND: begin
          wait_r <= wait_r + 1'b1;
          if (wait_r == CW'(`E_PULSE_CYCLES)) begin
            pu_r <= PU_HOLD;
          end
        end
        PU_HOLD: begin
          wait_r <= wait_end ? '0 : wait_r + 1'b1;
          if (wait_end) begin
            if (code_idx_r == 3'(`INIT_CODE_COUNT + 1)) begin
              pu_r <= PU_DONE;
              init_done_r <= 1'b1; // see [R6]
            end else begin
              code_idx_r <= code_idx_r + 1'b1;
              pu_r <= PU_SEND;
            end
          end
        end
        PU_DONE: begin
          init_done_r <= 1'b1;
        end
        default: pu_r <= PU_WAIT;
      endcase
    end
  end

  // Enable high in the early part of a step so the fall starts the hold
  assign pu_e = (pu_r == PU_SEND) && (wait_r != '0);

  // Host strobe edge detect; only the falling edge captures
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      strobe_d_r <= 1'b0;
    end else begin
      strobe_d_r <= host_write;
    end
  end
  assign strobe_fall = strobe_d_r && !host_write; // see [R14] see [R17]

  // Byte latch and ready; edges while not ready are dropped
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      latch_r <= 8'h00;
      ready_r <= 1'b0;
    end else if (ready_r && strobe_fall) begin
      latch_r <= host_byte_in; // see [R8]
      ready_r <= 1'b0;
    end else if (!ready_r && init_done_r && mn_r == MN_IDLE &&
                 !fifo_out_valid && !fifo_in_valid) begin
      ready_r <= 1'b1; // see [R7] see [R9]
    end
  end
  assign ready = ready_r; // see [R10]

  // Latched byte passes through the FIFO toward the display writer
  logic pend_r;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pend_r <= 1'b0;
    end else if (ready_r && strobe_fall) begin
      pend_r <= 1'b1;
    end else if (fifo_in_ready) begin
      pend_r <= 1'b0;
    end
  end
  assign fifo_in_valid = pend_r;

  byte_fifo #(
    .WIDTH(`BYTE_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(latch_r),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Main writer stalls the FIFO until the previous character is done
  assign fifo_out_ready = init_done_r && (mn_r == MN_IDLE);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mn_r <= MN_IDLE;
      e_cnt_r <= '0;
    end else begin
      case (mn_r)
        MN_IDLE: begin
          e_cnt_r <= '0;
          if (fifo_out_valid && fifo_out_ready) begin
            mn_r <= MN_SETUP;
          end
        end
        MN_SETUP: mn_r <= MN_STROBE;
        MN_STROBE: begin
          e_cnt_r <= e_cnt_r + 1'b1;
          if (e_cnt_r == EW'(`E_PULSE_CYCLES - 1)) begin
            mn_r <= MN_HOLD;
          end
        end
        MN_HOLD: mn_r <= MN_GAP;
        MN_GAP: mn_r <= MN_IDLE;
        default: mn_r <= MN_IDLE;
      endcase
    end
  end

  // Display pins registered; data and select stable across the E fall
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rs_r <= `RS_COMMAND;
      e_r <= 1'b0;
      db_r <= 8'h00;
    end else if (!init_done_r) begin
      rs_r <= `RS_COMMAND; // see [R16]
      db_r <= pu_byte;
      e_r <= pu_e; // see [R1]
    end else begin
      if (mn_r == MN_IDLE && fifo_out_valid) begin
        db_r <= fifo_out_data;
        rs_r <= `RS_DATA; // see [R16]
      end
      e_r <= (mn_r == MN_STROBE); // see [R1]
    end
  end

  assign display_register_select_out = rs_r;
  assign display_rw_out = `RW_WRITE; // see [R2]
  assign display_enable_out = e_r;
  assign display_byte_out = db_r;
endmodule

//--- tb/lcd_model.sv
// Display module model: latches select and byte on enable fall
`timescale 1ns/10ps
module lcd_model (
  // Display pins
  input wire logic rs,
  input wire logic rw,
  input wire logic en,
  input wire logic [7:0] db,
  // Capture record
  output logic [8:0] last,
  output int cnt
);
  logic en_q = 1'b0;
  initial last = 9'h000;
  initial cnt = 0;
  // Reads are not modelled, so a read level drops the write
  // Unknown-to-low at power-up is not a real enable fall
  always @(en) begin
    if (en_q === 1'b1 && en === 1'b0 && rw === 1'b0) begin
      last = {rs, db};
      cnt = cnt + 1;
    end
    en_q = en;
  end
endmodule

//--- tb/lcd_write_ctl_chk.sv
// Port checker for the display write controller
`timescale 1ns/10ps
module lcd_write_ctl_chk #(
  parameter int STEP_WAIT = 200
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Host side
  input wire logic [7:0] host_byte_in,
  input wire logic host_write,
  input wire logic ready,
  // Display side
  input wire logic display_register_select_out,
  input wire logic display_rw_out,
  input wire logic display_enable_out,
  input wire logic [7:0] display_byte_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence take_s;
    ready && $fell(host_write);
  endsequence
  rw_write_a: assert property (!display_rw_out)
    else $error("rw left write level");
  ready_drop_a: assert property (take_s |=> !ready)
    else $error("ready stayed high after write");
  enable_excl_a: assert property (display_enable_out |-> !ready)
    else $error("ready high during enable");
  enable_width_a: assert property (
    $rose(display_enable_out) |-> display_enable_out [*8])
    else $error("enable pulse too short");
  byte_hold_a: assert property (display_enable_out |->
    $stable(display_byte_out) && $stable(display_register_select_out))
    else $error("data moved under enable");
  char_select_a: assert property (
    take_s |-> ##[1:10] display_register_select_out)
    else $error("character sent as command");
  byte_carry_a: assert property (take_s |-> ##3
    (display_byte_out == $past(host_byte_in, 3) &&
     display_register_select_out))
    else $error("captured byte not shown to display");
  ready_back_a: assert property (take_s |-> ##[52:120] ready)
    else $error("ready did not return");
  ready_keep_a: assert property (
    ready && !$fell(host_write) |=> ready)
    else $error("ready dropped without write");
endmodule
bind lcd_write_ctl lcd_write_ctl_chk #(.STEP_WAIT(STEP_WAIT)) i_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .host_byte_in(host_byte_in),
  .host_write(host_write), .ready(ready),
  .display_register_select_out(display_register_select_out),
  .display_rw_out(display_rw_out),
  .display_enable_out(display_enable_out),
  .display_byte_out(display_byte_out));

//--- tb/tb_top.sv
// Testbench for the display write controller
`timescale 1ns/10ps
module tb_top;
  localparam int WAIT = 200;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] hb = 8'h00;
  logic hw = 1'b0;
  logic ready, rs, rw, en;
  logic [7:0] db;
  logic [8:0] last;
  int cnt;
  int fail_count = 0;
  int tests_run = 0;
  logic [8:0] got[$];
  always #5 sys_clk = ~sys_clk;
  always @(cnt) got.push_back(last);
  lcd_write_ctl #(.STEP_WAIT(WAIT)) i_lcd_write_ctl (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .host_byte_in(hb),
    .host_write(hw), .ready(ready), .display_register_select_out(rs),
    .display_rw_out(rw), .display_enable_out(en),
    .display_byte_out(db));
  lcd_model i_lcd_model (.rs(rs), .rw(rw), .en(en), .db(db),
    .last(last), .cnt(cnt));
  task automatic check9(string what, logic [8:0] exp, logic [8:0] act);
    tests_run++;
    if (act !== exp) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", what, exp, act);
    end
  endtask
  task automatic check_n(string what, int exp, int act);
    tests_run++;
    if (act != exp) begin
      fail_count++;
      $display("MISMATCH %s exp %0d got %0d", what, exp, act);
    end
  endtask
  task automatic wait_ready(output int n);
    n = 0;
    while (ready !== 1'b1 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    if (ready !== 1'b1) begin
      fail_count++;
      $display("MISMATCH ready exp 1 got %b", ready);
    end
  endtask
  // Host side: byte held until the strobe fall is seen
  // A long strobe must not be taken at its rise
  task automatic write_byte(logic [7:0] b, int hold = 1);
    @(posedge sys_clk);
    hb <= b;
    hw <= 1'b1;
    repeat (hold - 1) @(posedge sys_clk);
    if (hold > 1) #1 check9("ready in strobe", 9'h001, {8'h00, ready});
    @(posedge sys_clk);
    hw <= 1'b0;
  endtask
  task automatic test_init();
    logic [8:0] c[6] = '{9'h000, 9'h038, 9'h006, 9'h00e, 9'h001, 9'h080};
    int n;
    got.delete();
    wait_ready(n);
    check_n("init time", 1, int'(n >= 7 * WAIT && n <= 7 * WAIT + 4));
    check_n("init codes", 6, got.size());
    foreach (c[i]) check9("init code", c[i], got[i]);
    $display("test_init done");
  endtask
  task automatic test_chars();
    logic [7:0] b[3] = '{8'h41, 8'h00, 8'hff};
    int n;
    foreach (b[i]) begin
      write_byte(b[i], i + 1);
      repeat (2) @(posedge sys_clk);
      #1 check9("ready low", 9'h000, {8'h00, ready});
      wait_ready(n);
      check9("char", {1'b1, b[i]}, last);
    end
    $display("test_chars done");
  endtask
  task automatic test_refuse();
    int c0;
    int n;
    c0 = cnt;
    write_byte(8'h52);
    repeat (4) @(posedge sys_clk);
    write_byte(8'h58);
    wait_ready(n);
    check_n("writes", c0 + 1, cnt);
    check9("kept", 9'h152, last);
    $display("test_refuse done");
  endtask
  // Reset lands mid-pulse, so the init must start over
  task automatic test_reset();
    write_byte(8'h33);
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1 check9("reset out", 9'h000, {ready, db});
    test_init();
    $display("test_reset done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    test_init();
    test_chars();
    test_refuse();
    test_reset();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    report_and_stop();
  end
endmodule
